// File: core/prot_pkg.sv
package prot_pkg;
  localparam logic [23:0] RAM_BASE = 24'h000000;
  localparam logic [23:0] RAM_HALF = 24'h001000;
  localparam logic [23:0] RAM_END = 24'h001fff;
  localparam logic [23:0] EE_BASE = 24'h100000;
  localparam logic [23:0] EE_HALF = 24'h110000;
  localparam logic [23:0] EE_END = 24'h11ffff;
  localparam logic [23:0] ROM_BASE = 24'h200000;
  localparam logic [23:0] ROM_HALF = 24'h220000;
  localparam logic [23:0] ROM_END = 24'h23ffff;
  localparam logic [23:0] SROW_BYTES = 24'h000080;
  localparam logic [23:0] SROW_BASE = EE_END - SROW_BYTES + 24'h000001;
  localparam logic [6:0] SROW_RO_END = 7'h20;
  localparam logic [6:0] SROW_WP_END = 7'h30;
  localparam logic [6:0] SROW_WO_END = 7'h50;
  localparam logic [23:0] SYSTEM_VECTOR_BASE = 24'hff0000;
  localparam logic [23:0] SYSTEM_VECTOR_END = 24'hff00ff;
  localparam logic [23:0] CONFIGURATION_VECTOR_BASE = 24'hff0100;
  localparam logic [23:0] CONFIGURATION_VECTOR_END = 24'hff01ff;
  localparam logic [23:0] USER_ENTRY = 24'h800000;
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_CAUSE = 8'h04;
  localparam logic [7:0] A_IRQ = 8'h08;
  localparam logic [7:0] A_CL_LO = 8'h0c;
  localparam logic [7:0] A_CL_HI = 8'h10;
  localparam logic [7:0] A_SIDX = 8'h14;
  localparam logic [7:0] A_SSTART = 8'h18;
  localparam logic [7:0] A_SEND = 8'h1c;
  localparam logic [7:0] A_SOFS = 8'h20;
  localparam logic [7:0] A_SATTR = 8'h24;
  localparam logic [7:0] A_SROW = 8'h28;
  localparam logic [7:0] A_CARD = 8'h2c;
  localparam logic [7:0] A_GRP = 8'h30;
  localparam logic [7:0] SFR_FIXED = 8'h00;
  localparam logic [15:0] GRP_ALL = 16'hffff;
  localparam int SEG_N = 64;
  typedef enum logic [1:0] {
    SEG_END = 2'b00, SEG_USE = 2'b01, SEG_SKIP = 2'b10
  } seg_code_t;
  typedef enum logic [1:0] {
    SUB_BOOT = 2'b00, SUB_TEST = 2'b01, SUB_CL = 2'b10
  } sub_mode_t;
  typedef enum logic [3:0] {
    C_NONE = 4'h0, C_SEG = 4'h1, C_RANGE = 4'h2, C_SYSTEM_VECTOR = 4'h3,
    C_RETURN_FROM_INTERRUPT = 4'h4, C_PART = 4'h5, C_EXT = 4'h6
  } cause_t;
  typedef struct packed {
    seg_code_t code;
    logic [2:0] rwx;
    logic [15:0] grp;
    logic [23:0] vstart;
    logic [23:0] vend;
    logic [23:0] ofs;
  } seg_t;
  typedef struct packed {
    logic vld;
    logic [1:0] kind;
    logic [23:0] vaddr;
    logic [7:0] wdata;
  } acc_t;
  typedef struct packed {
    logic ok;
    logic [23:0] paddr;
    logic [7:0] wdata;
  } acc_res_t;
  typedef struct packed {
    logic call_vld;
    logic [23:0] call_addr;
    logic irq_take;
    logic exc_take;
    logic return_from_interrupt;
    logic boot_done;
  } mode_evt_t;
  typedef struct packed {
    logic vld;
    logic wr;
    logic [3:0] grp;
    logic no_rd;
    logic no_wr;
    logic [7:0] rdata;
  } sfr_t;
endpackage : prot_pkg

// File: core/prot_unit.sv
// Function
// - Top 128 EEPROM bytes form security row
// - 32-byte row area readable, writable only with super flag set
// - 16-byte area writable until locked
// - 32-byte area bits only rise
// - Disabled card blocks application start-up
// - Fixed halves; test mode sees both
// - Segments set in system, checked user
// - Entry holds rights, bounds, offset, groups
// - Offset added; result partition checked
// - 64 entries; end/skip codes split table
// - Per-group rights for 16 register groups
// - Full rights boot/test/system; two regs contactless
// - Exception on forbidden or unimplemented address
// - Denied write ignored, denied read fixed
// - Three register banks, one per mode group
// - Super flag, system flag, both clear user
// - System vector call from user only
// - Configuration vector enters contactless firmware
// - Exceptions set system flag; irq configurable
// - Return restores flags; user checked
// - System call to entry enters user, no push
// - Direct flag writes only clear
// - Boot only after reset, never re-entered
// - Exception cause recorded for software
`timescale 1ns/100ps
module prot_unit #(
  parameter bit HAS_CL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire prot_pkg::acc_t acc,
  input wire logic [7:0] ee_old,
  output prot_pkg::acc_res_t res_q,
  input wire prot_pkg::mode_evt_t evt,
  output logic call_no_push,
  input wire prot_pkg::sfr_t special_function_register,
  output logic sfr_wr_en,
  output logic [7:0] sfr_rdata_q,
  output logic [1:0] sfr_bank,
  output logic [15:0] grp_now,
  output logic exc_q,
  output logic sup_out,
  output logic sys_out,
  output logic card_burn_q,
  input wire logic test_avail_pin,
  input wire logic card_feat_pin,
  input wire logic card_fuse_pin
);
  logic sup_q;
  logic sys_q;
  prot_pkg::sub_mode_t sub_q;
  logic sav_sup_q;
  logic sav_sys_q;
  logic irq_act_q;
  logic irq_user_q;
  logic [3:0] cause_q;
  logic [7:0] cl_lo_q;
  logic [7:0] cl_hi_q;
  logic [5:0] sidx_q;
  logic [23:0] sstart_q;
  logic [23:0] send_q;
  logic [23:0] sofs_q;
  logic wp_q;
  logic [15:0] ugrp_q;
  prot_pkg::seg_t seg_q [prot_pkg::SEG_N];
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] pin_q;

  // Pins: change accepted once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      s1_q <= {card_fuse_pin, card_feat_pin, test_avail_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic test_ok;
  logic app_ok;
  assign test_ok = pin_q[0];
  assign app_ok = !(pin_q[1] && pin_q[2]);

  logic is_user;
  logic is_sys;
  logic is_test;
  logic is_cl;
  assign is_user = !sup_q && !sys_q;
  assign is_sys = !sup_q && sys_q;
  assign is_test = sup_q && sub_q == prot_pkg::SUB_TEST;
  assign is_cl = sup_q && sub_q == prot_pkg::SUB_CL;
  assign sup_out = sup_q;
  assign sys_out = sys_q;
  assign sfr_bank = sup_q ? 2'h2 : (sys_q ? 2'h1 : 2'h0);

  logic wr_priv;
  assign wr_priv = reg_wr && (sys_q || sup_q);

  // Segment lookup, first live entry wins
  logic hit;
  logic stop;
  prot_pkg::seg_t hit_e;
  always_comb begin
    hit = 1'b0;
    stop = 1'b0;
    hit_e = '0;
    for (int i = 0; i < prot_pkg::SEG_N; i++) begin
      if (!hit && !stop) begin
        if (seg_q[i].code == prot_pkg::SEG_END) begin
          stop = 1'b1;
        end else if (seg_q[i].code == prot_pkg::SEG_USE &&
                     acc.vaddr >= seg_q[i].vstart &&
                     acc.vaddr <= seg_q[i].vend) begin
          hit = 1'b1;
          hit_e = seg_q[i];
        end
      end
    end
  end

  logic right_ok;
  logic [23:0] paddr;
  assign right_ok = hit && hit_e.rwx[acc.kind];
  assign paddr = is_user ? acc.vaddr + hit_e.ofs : acc.vaddr;

  logic in_ram;
  logic in_ee;
  logic in_rom;
  logic part_ok;
  assign in_ram = paddr <= prot_pkg::RAM_END;
  assign in_ee = paddr >= prot_pkg::EE_BASE && paddr <= prot_pkg::EE_END;
  assign in_rom = paddr >= prot_pkg::ROM_BASE &&
                  paddr <= prot_pkg::ROM_END;
  // Normal modes see only the upper half of each memory
  always_comb begin
    part_ok = is_test;
    if (in_ram && paddr >= prot_pkg::RAM_HALF) begin
      part_ok = 1'b1;
    end
    if (in_ee && paddr >= prot_pkg::EE_HALF) begin
      part_ok = 1'b1;
    end
    if (in_rom && paddr >= prot_pkg::ROM_HALF) begin
      part_ok = 1'b1;
    end
  end

  logic in_srow;
  logic [6:0] srow_off;
  logic is_wr;
  logic wr_block;
  logic wr_once;
  assign in_srow = paddr >= prot_pkg::SROW_BASE &&
                   paddr <= prot_pkg::EE_END;
  assign srow_off = paddr[6:0];
  assign is_wr = acc.kind == 2'h1;
  // Security row only guards the embedded software modes
  always_comb begin
    wr_block = 1'b0;
    wr_once = 1'b0;
    if (in_srow && is_wr && !sup_q) begin
      if (srow_off < prot_pkg::SROW_RO_END) begin
        wr_block = 1'b1;
      end else if (srow_off < prot_pkg::SROW_WP_END) begin
        wr_block = wp_q;
      end else if (srow_off < prot_pkg::SROW_WO_END) begin
        wr_once = 1'b1;
      end else begin
        wr_block = 1'b1;
      end
    end
  end

  logic acc_exc;
  logic [3:0] acc_cause;
  always_comb begin
    acc_exc = 1'b0;
    acc_cause = prot_pkg::C_NONE;
    if (acc.vld) begin
      if (is_user && !right_ok) begin
        acc_exc = 1'b1;
        acc_cause = prot_pkg::C_SEG;
      end else if (!(in_ram || in_ee || in_rom)) begin
        acc_exc = 1'b1;
        acc_cause = prot_pkg::C_RANGE;
      end else if (!part_ok) begin
        acc_exc = 1'b1;
        acc_cause = prot_pkg::C_PART;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      res_q <= '0;
    end else begin
      res_q.ok <= acc.vld && !acc_exc && !wr_block;
      res_q.paddr <= paddr;
      res_q.wdata <= wr_once ? (acc.wdata | ee_old) : acc.wdata;
    end
  end

  // Groups of the segment the user code runs from
  always_ff @(posedge mclk) begin
    if (rst) begin
      ugrp_q <= 16'h0000;
    end else if (acc.vld && is_user && right_ok && acc.kind == 2'h2) begin
      ugrp_q <= hit_e.grp;
    end
  end

  always_comb begin
    if (is_user) begin
      grp_now = ugrp_q;
    end else if (is_cl) begin
      grp_now = {cl_hi_q, cl_lo_q};
    end else begin
      grp_now = prot_pkg::GRP_ALL;
    end
  end

  logic sfr_ok_rd;
  assign sfr_ok_rd = grp_now[special_function_register.grp] && !special_function_register.no_rd;
  assign sfr_wr_en = special_function_register.vld && special_function_register.wr && grp_now[special_function_register.grp] &&
                     !special_function_register.no_wr;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata_q <= prot_pkg::SFR_FIXED;
    end else if (special_function_register.vld && !special_function_register.wr) begin
      sfr_rdata_q <= sfr_ok_rd ? special_function_register.rdata : prot_pkg::SFR_FIXED;
    end
  end

  logic call_sv;
  logic call_cv;
  logic call_usr;
  logic system_vector_bad;
  logic return_from_interrupt_bad;
  logic any_exc;
  assign call_sv = evt.call_vld && evt.call_addr >= prot_pkg::SYSTEM_VECTOR_BASE &&
                   evt.call_addr <= prot_pkg::SYSTEM_VECTOR_END;
  assign call_cv = evt.call_vld && evt.call_addr >= prot_pkg::CONFIGURATION_VECTOR_BASE &&
                   evt.call_addr <= prot_pkg::CONFIGURATION_VECTOR_END && HAS_CL;
  assign call_usr = evt.call_vld && is_sys &&
                    evt.call_addr == prot_pkg::USER_ENTRY;
  assign call_no_push = call_usr;
  assign system_vector_bad = call_sv && !is_user;
  assign return_from_interrupt_bad = evt.return_from_interrupt && is_user &&
                    !(irq_user_q && irq_act_q);
  assign any_exc = acc_exc || system_vector_bad || return_from_interrupt_bad || evt.exc_take;

  logic mode_wr;
  assign mode_wr = reg_wr && reg_addr == prot_pkg::A_MODE;

  // Mode flags: exception, return, call, interrupt, boot done, then direct write
  always_ff @(posedge mclk) begin
    if (rst) begin
      sup_q <= 1'b1;
      sys_q <= 1'b0;
      sub_q <= prot_pkg::SUB_BOOT;
      sav_sup_q <= 1'b0;
      sav_sys_q <= 1'b0;
      irq_act_q <= 1'b0;
    end else if (any_exc) begin
      sav_sup_q <= sup_q;
      sav_sys_q <= sys_q;
      sys_q <= 1'b1;
    end else if (evt.return_from_interrupt) begin
      sup_q <= sav_sup_q;
      sys_q <= sav_sys_q;
      irq_act_q <= 1'b0;
    end else if (call_sv) begin
      sav_sup_q <= sup_q;
      sav_sys_q <= sys_q;
      sys_q <= 1'b1;
    end else if (call_cv) begin
      sav_sup_q <= sup_q;
      sav_sys_q <= sys_q;
      sup_q <= 1'b1;
      sub_q <= prot_pkg::SUB_CL;
    end else if (call_usr) begin
      sys_q <= 1'b0;
    end else if (evt.irq_take) begin
      sav_sup_q <= sup_q;
      sav_sys_q <= sys_q;
      irq_act_q <= 1'b1;
      if (!irq_user_q) begin
        sys_q <= 1'b1;
      end
    end else if (evt.boot_done && sup_q && sub_q == prot_pkg::SUB_BOOT) begin
      if (test_ok) begin
        sub_q <= prot_pkg::SUB_TEST;
      end else if (app_ok) begin
        sup_q <= 1'b0;
        sys_q <= 1'b1;
        sub_q <= prot_pkg::SUB_CL;
      end
    end else if (mode_wr) begin
      sys_q <= sys_q && reg_wdata[0];
      sup_q <= sup_q && reg_wdata[1];
      if (!reg_wdata[1]) begin
        sub_q <= prot_pkg::SUB_CL;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      exc_q <= 1'b0;
      cause_q <= prot_pkg::C_NONE;
    end else begin
      exc_q <= any_exc;
      if (acc_exc) begin
        cause_q <= acc_cause;
      end else if (system_vector_bad) begin
        cause_q <= prot_pkg::C_SYSTEM_VECTOR;
      end else if (return_from_interrupt_bad) begin
        cause_q <= prot_pkg::C_RETURN_FROM_INTERRUPT;
      end else if (evt.exc_take) begin
        cause_q <= prot_pkg::C_EXT;
      end
    end
  end

  // Configuration registers; user-mode writes are dropped except the security row lock
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_user_q <= 1'b0;
      cl_lo_q <= 8'h00;
      cl_hi_q <= 8'h00;
      wp_q <= 1'b0;
      card_burn_q <= 1'b0;
    end else begin
      card_burn_q <= 1'b0;
      if (wr_priv && reg_addr == prot_pkg::A_IRQ && is_sys) begin
        irq_user_q <= reg_wdata[0];
      end
      if (wr_priv && !is_cl && reg_addr == prot_pkg::A_CL_LO) begin
        cl_lo_q <= reg_wdata[7:0];
      end
      if (wr_priv && !is_cl && reg_addr == prot_pkg::A_CL_HI) begin
        cl_hi_q <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == prot_pkg::A_SROW && reg_wdata[0]) begin
        wp_q <= 1'b1;
      end
      if (wr_priv && reg_addr == prot_pkg::A_CARD && reg_wdata[0]) begin
        card_burn_q <= 1'b1;
      end
    end
  end

  logic seg_wr;
  assign seg_wr = reg_wr && is_sys;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sidx_q <= 6'h00;
      sstart_q <= 24'h000000;
      send_q <= 24'h000000;
      sofs_q <= 24'h000000;
      for (int i = 0; i < prot_pkg::SEG_N; i++) begin
        seg_q[i] <= '0;
      end
    end else if (seg_wr) begin
      case (reg_addr)
        prot_pkg::A_SIDX: sidx_q <= reg_wdata[5:0];
        prot_pkg::A_SSTART: sstart_q <= reg_wdata[23:0];
        prot_pkg::A_SEND: send_q <= reg_wdata[23:0];
        prot_pkg::A_SOFS: sofs_q <= reg_wdata[23:0];
        prot_pkg::A_SATTR: begin
          seg_q[sidx_q].code <= prot_pkg::seg_code_t'(reg_wdata[1:0]);
          seg_q[sidx_q].rwx <= reg_wdata[4:2];
          seg_q[sidx_q].grp <= reg_wdata[31:16];
          seg_q[sidx_q].vstart <= sstart_q;
          seg_q[sidx_q].vend <= send_q;
          seg_q[sidx_q].ofs <= sofs_q;
        end
        default: sidx_q <= sidx_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        prot_pkg::A_MODE: reg_rdata <= {28'h0, sub_q, sup_q, sys_q};
        prot_pkg::A_CAUSE: reg_rdata <= {28'h0, cause_q};
        prot_pkg::A_IRQ: reg_rdata <= {30'h0, irq_act_q, irq_user_q};
        prot_pkg::A_CL_LO: reg_rdata <= {24'h0, cl_lo_q};
        prot_pkg::A_CL_HI: reg_rdata <= {24'h0, cl_hi_q};
        prot_pkg::A_SIDX: reg_rdata <= {26'h0, sidx_q};
        prot_pkg::A_SROW: reg_rdata <= {31'h0, wp_q};
        prot_pkg::A_CARD: reg_rdata <= {30'h0, app_ok, 1'b0};
        prot_pkg::A_GRP: reg_rdata <= {16'h0, grp_now};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  mode_clear_a: assert property (@(posedge mclk) disable iff (rst)
    mode_wr && !any_exc && !evt.return_from_interrupt && !evt.call_vld &&
    !evt.irq_take && !evt.boot_done |=> !$rose(sys_q) && !$rose(sup_q))
    else $error("mode flag set by direct write");
  system_vector_exc_a: assert property (@(posedge mclk) disable iff (rst)
    system_vector_bad && !acc_exc |=> exc_q && cause_q == prot_pkg::C_SYSTEM_VECTOR)
    else $error("system vector call not trapped");
  user_seg_a: assert property (@(posedge mclk) disable iff (rst)
    acc.vld && is_user && !hit |=> exc_q && !res_q.ok && sys_q)
    else $error("user segment miss not trapped");
  grp_full_a: assert property (@(posedge mclk) disable iff (rst)
    (is_sys || is_test) |-> grp_now == prot_pkg::GRP_ALL)
    else $error("privileged groups not full");
  ro_area_a: assert property (@(posedge mclk) disable iff (rst)
    acc.vld && is_wr && in_srow && !sup_q &&
    srow_off < prot_pkg::SROW_RO_END |=> !res_q.ok)
    else $error("read-only row written");
  write_once_a: assert property (@(posedge mclk) disable iff (rst)
    acc.vld && wr_once |=>
    (res_q.wdata & $past(ee_old)) == $past(ee_old))
    else $error("one-time bit cleared");
  no_boot_a: assert property (@(posedge mclk) disable iff (rst)
    sub_q != prot_pkg::SUB_BOOT |=> sub_q != prot_pkg::SUB_BOOT)
    else $error("boot mode re-entered");
  user_call_a: assert property (@(posedge mclk) disable iff (rst)
    call_usr && !any_exc && !evt.return_from_interrupt |=> !sys_q && !sup_q)
    else $error("user entry call failed");
  sfr_deny_a: assert property (@(posedge mclk) disable iff (rst)
    special_function_register.vld && !special_function_register.wr && !sfr_ok_rd |=>
    sfr_rdata_q == prot_pkg::SFR_FIXED)
    else $error("denied register read leaked");
  card_off_a: assert property (@(posedge mclk) disable iff (rst)
    sup_q && sub_q == prot_pkg::SUB_BOOT && !app_ok && !test_ok
    |=> sup_q)
    else $error("disabled card started");
endmodule : prot_unit

// File: dv/cpu_mem_model.sv
`timescale 1ns/100ps
module cpu_mem_model (
  input wire logic mclk,
  input wire prot_pkg::acc_t acc,
  input wire prot_pkg::acc_res_t res_q,
  output logic [7:0] ee_old
);
  logic [7:0] row_q [128];
  logic [7:0] last_q;
  logic wr_q;
  initial begin
    for (int i = 0; i < 128; i++) begin
      row_q[i] = 8'h0f;
    end
    last_q = 8'h00;
    wr_q = 1'b0;
  end
  // Idle lane shows the inverse, so a stale byte cannot pass
  assign ee_old = acc.vld ? row_q[acc.vaddr[6:0]] : ~last_q;
  always @(posedge mclk) begin
    wr_q <= acc.vld && acc.kind == 2'd1;
    if (acc.vld) begin
      last_q <= row_q[acc.vaddr[6:0]];
    end
    // Only what the unit let through lands in the row
    if (wr_q && res_q.ok && res_q.paddr >= prot_pkg::SROW_BASE &&
        res_q.paddr <= prot_pkg::EE_END) begin
      row_q[res_q.paddr[6:0]] <= res_q.wdata;
    end
  end
endmodule : cpu_mem_model

// File: dv/prot_unit_tb.sv
`timescale 1ns/100ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  err_total++; $display("wrong value at %0t: %s", $time, m); end end
module prot_unit_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  prot_pkg::acc_t acc = '0;
  logic [7:0] ee_old;
  prot_pkg::acc_res_t res_q;
  prot_pkg::mode_evt_t evt = '0;
  logic call_no_push;
  prot_pkg::sfr_t special_function_register = '0;
  logic sfr_wr_en;
  logic [7:0] sfr_rdata_q;
  logic [1:0] sfr_bank;
  logic [15:0] grp_now;
  logic exc_q;
  logic sup_out;
  logic sys_out;
  logic card_burn_q;
  logic test_pin = 1'b0;
  logic feat_pin = 1'b0;
  logic fuse_pin = 1'b0;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rd_v;
  logic exc_v;
  logic np_v;
  logic [23:0] rb;

  prot_unit dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc(acc), .ee_old(ee_old), .res_q(res_q),
    .evt(evt), .call_no_push(call_no_push), .special_function_register(special_function_register),
    .sfr_wr_en(sfr_wr_en), .sfr_rdata_q(sfr_rdata_q), .sfr_bank(sfr_bank),
    .grp_now(grp_now), .exc_q(exc_q), .sup_out(sup_out), .sys_out(sys_out),
    .card_burn_q(card_burn_q), .test_avail_pin(test_pin),
    .card_feat_pin(feat_pin), .card_fuse_pin(fuse_pin));
  cpu_mem_model cpu (.mclk(mclk), .acc(acc), .res_q(res_q),
    .ee_old(ee_old));

  always #2.5 mclk = ~mclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Bounded run so a stuck handshake cannot hang the job
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : reg_read

  function automatic prot_pkg::mode_evt_t ev_call(input logic [23:0] a);
    ev_call = '0;
    ev_call.call_vld = 1'b1;
    ev_call.call_addr = a;
  endfunction : ev_call

  function automatic prot_pkg::mode_evt_t ev_flag(input int b);
    ev_flag = '0;
    ev_flag[b] = 1'b1;
  endfunction : ev_flag

  task automatic ev(input prot_pkg::mode_evt_t e);
    @(posedge mclk);
    evt <= e;
    #1 np_v = call_no_push;
    @(posedge mclk);
    evt <= '0;
    #1 exc_v = exc_q;
  endtask : ev

  task automatic access(input logic [1:0] k, input logic [23:0] va,
      input logic [7:0] wd, input logic ok, input logic [23:0] pa,
      input logic [7:0] wx, input logic ex, input prot_pkg::cause_t c);
    @(posedge mclk);
    acc <= {1'b1, k, va, wd};
    @(posedge mclk);
    acc <= '0;
    #1;
    `CHK(res_q.ok, ok, "access ok")
    `CHK(exc_q, ex, "access trap")
    if (ok) begin
      `CHK(res_q.paddr, pa, "physical address")
    end
    if (ok && k == 2'd1) begin
      `CHK(res_q.wdata, wx, "write data")
    end
    if (ex) begin
      reg_read(prot_pkg::A_CAUSE);
      `CHK(rd_v[3:0], c, "trap cause")
    end
  endtask : access

  task automatic sfr_do(input logic w, input logic [3:0] g,
      input logic nr, input logic [7:0] d, input logic x);
    @(posedge mclk);
    special_function_register <= {1'b1, w, g, nr, 1'b0, d};
    #1;
    if (w) begin
      `CHK(sfr_wr_en, x, "register write gate")
    end
    @(posedge mclk);
    special_function_register <= '0;
    #1;
    if (!w) begin
      `CHK(sfr_rdata_q, x ? d : prot_pkg::SFR_FIXED, "register read")
    end
  endtask : sfr_do

  task automatic seg_wr(input logic [5:0] i, input logic [1:0] cd,
      input logic [2:0] r, input logic [15:0] g, input logic [23:0] vs,
      input logic [23:0] ve, input logic [23:0] of);
    reg_write(prot_pkg::A_SIDX, {26'h0, i});
    reg_write(prot_pkg::A_SSTART, {8'h00, vs});
    reg_write(prot_pkg::A_SEND, {8'h00, ve});
    reg_write(prot_pkg::A_SOFS, {8'h00, of});
    reg_write(prot_pkg::A_SATTR, {g, 11'h0, r, cd});
  endtask : seg_wr

  task automatic mode_chk(input logic [1:0] m);
    `CHK({sup_out, sys_out}, m, "mode flags")
  endtask : mode_chk

  task automatic go_user();
    reg_write(prot_pkg::A_MODE, 32'h0);
    #1 mode_chk(2'b00);
  endtask : go_user

  task automatic do_reset(input logic t, input logic f, input logic u);
    @(posedge mclk);
    test_pin <= t;
    feat_pin <= f;
    fuse_pin <= u;
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Pin synchronisers restart in reset; boot_done must wait for them
    repeat (4) @(posedge mclk);
  endtask : do_reset

  task automatic t_start();
    reg_read(prot_pkg::A_MODE);
    `CHK(rd_v[3:0], 4'h2, "boot after reset")
    `CHK(grp_now, prot_pkg::GRP_ALL, "boot groups")
    `CHK(sfr_bank, 2'd2, "super bank")
    reg_read(8'hfc);
    `CHK(rd_v, 32'h0, "unmapped read")
    ev(ev_flag(0));
    mode_chk(2'b01);
    `CHK(sfr_bank, 2'd1, "system bank")
    `CHK(grp_now, prot_pkg::GRP_ALL, "system groups")
    $display("test start done");
  endtask : t_start

  task automatic t_part();
    access(0, prot_pkg::RAM_BASE, 0, 0, 0, 0, 1, prot_pkg::C_PART);
    access(0, 24'h001010, 0, 1, 24'h001010, 0, 0, prot_pkg::C_NONE);
    access(0, 24'h003000, 0, 0, 0, 0, 1, prot_pkg::C_RANGE);
    access(1, 24'h120000, 0, 0, 0, 0, 1, prot_pkg::C_RANGE);
    $display("test partition done");
  endtask : t_part

  task automatic t_seg();
    seg_wr(0, 2'd1, 3'b101, 16'h0005, 24'h0, 24'h0000ff, 24'h001000);
    seg_wr(1, 2'd2, 3'b111, 16'h0, 24'h000200, 24'h0002ff, 24'h001000);
    seg_wr(2, 2'd1, 3'b111, 16'hffff, 24'h000100, 24'h0001ff, 24'h0);
    go_user();
    access(0, 24'h000010, 0, 1, 24'h001010, 0, 0, prot_pkg::C_NONE);
    access(2, 24'h000020, 0, 1, 24'h001020, 0, 0, prot_pkg::C_NONE);
    `CHK(grp_now, 16'h0005, "user groups")
    `CHK(sfr_bank, 2'd0, "user bank")
    sfr_do(0, 4'd1, 0, 8'h5a, 0);
    sfr_do(0, 4'd0, 0, 8'h5a, 1);
    sfr_do(1, 4'd2, 0, 8'h00, 1);
    sfr_do(1, 4'd1, 0, 8'h00, 0);
    sfr_do(0, 4'd0, 1, 8'h5a, 0);
    access(1, 24'h000010, 0, 0, 0, 0, 1, prot_pkg::C_SEG);
    mode_chk(2'b01);
    go_user();
    access(0, 24'h000150, 0, 0, 0, 0, 1, prot_pkg::C_PART);
    go_user();
    access(0, 24'h000250, 0, 0, 0, 0, 1, prot_pkg::C_SEG);
    $display("test segments done");
  endtask : t_seg

  task automatic t_mode();
    go_user();
    reg_write(prot_pkg::A_MODE, 32'h3);
    #1 mode_chk(2'b00);
    ev(ev_flag(1));
    `CHK(exc_v, 1'b1, "user return trap")
    reg_read(prot_pkg::A_CAUSE);
    `CHK(rd_v[3:0], prot_pkg::C_RETURN_FROM_INTERRUPT, "return cause")
    mode_chk(2'b01);
    ev(ev_call(prot_pkg::SYSTEM_VECTOR_BASE));
    `CHK(exc_v, 1'b1, "system vector from system")
    reg_read(prot_pkg::A_CAUSE);
    `CHK(rd_v[3:0], prot_pkg::C_SYSTEM_VECTOR, "vector cause")
    go_user();
    ev(ev_call(prot_pkg::SYSTEM_VECTOR_END));
    `CHK(exc_v, 1'b0, "system vector from user")
    mode_chk(2'b01);
    ev(ev_call(prot_pkg::USER_ENTRY));
    `CHK(np_v, 1'b1, "entry call without push")
    mode_chk(2'b00);
    ev(ev_call(prot_pkg::SYSTEM_VECTOR_BASE));
    reg_write(prot_pkg::A_IRQ, 32'h1);
    go_user();
    ev(ev_flag(3));
    mode_chk(2'b00);
    ev(ev_flag(1));
    `CHK(exc_v, 1'b0, "user return allowed")
    mode_chk(2'b00);
    ev(ev_flag(2));
    `CHK(exc_v, 1'b1, "external exception")
    mode_chk(2'b01);
    reg_read(prot_pkg::A_CAUSE);
    `CHK(rd_v[3:0], prot_pkg::C_EXT, "external cause")
    $display("test modes done");
  endtask : t_mode

  task automatic t_row();
    rb = prot_pkg::SROW_BASE;
    access(1, rb, 8'h55, 0, 0, 0, 0, prot_pkg::C_NONE);
    access(0, rb, 0, 1, rb, 0, 0, prot_pkg::C_NONE);
    access(1, rb - 24'h1, 8'h01, 1, rb - 24'h1, 8'h01, 0,
      prot_pkg::C_NONE);
    access(1, rb + 24'h20, 8'h11, 1, rb + 24'h20, 8'h11, 0,
      prot_pkg::C_NONE);
    reg_write(prot_pkg::A_SROW, 32'h1);
    access(1, rb + 24'h2f, 8'h11, 0, 0, 0, 0, prot_pkg::C_NONE);
    access(1, rb + 24'h30, 8'hf0, 1, rb + 24'h30, 8'hff, 0,
      prot_pkg::C_NONE);
    access(1, rb + 24'h30, 8'h00, 1, rb + 24'h30, 8'hff, 0,
      prot_pkg::C_NONE);
    access(1, rb + 24'h50, 8'h01, 0, 0, 0, 0, prot_pkg::C_NONE);
    reg_write(prot_pkg::A_CARD, 32'h1);
    #1 `CHK(card_burn_q, 1'b1, "card burn request")
    $display("test security row done");
  endtask : t_row

  task automatic t_cl();
    ev(ev_call(prot_pkg::CONFIGURATION_VECTOR_BASE));
    reg_read(prot_pkg::A_MODE);
    `CHK(rd_v[3:1], {prot_pkg::SUB_CL, 1'b1}, "firmware mode")
    `CHK(grp_now, 16'h0000, "firmware groups")
    reg_write(prot_pkg::A_CL_LO, 32'hff);
    #1 `CHK(grp_now, 16'h0000, "firmware groups locked")
    $display("test firmware mode done");
  endtask : t_cl

  task automatic t_boot();
    do_reset(1, 0, 0);
    ev(ev_flag(0));
    reg_read(prot_pkg::A_MODE);
    `CHK(rd_v[3:0], 4'h6, "test mode")
    access(0, prot_pkg::RAM_BASE, 0, 1, prot_pkg::RAM_BASE, 0, 0,
      prot_pkg::C_NONE);
    do_reset(0, 1, 1);
    ev(ev_flag(0));
    reg_read(prot_pkg::A_MODE);
    `CHK(rd_v[3:0], 4'h2, "disabled card stays in boot")
    reg_read(prot_pkg::A_CARD);
    `CHK(rd_v[1], 1'b0, "start-up refused")
    $display("test boot paths done");
  endtask : t_boot

  initial begin
    do_reset(0, 0, 0);
    t_start();
    t_part();
    t_seg();
    t_mode();
    t_row();
    t_cl();
    t_boot();
    print_verdict();
  end
endmodule : prot_unit_tb
